// ---- rtl/isp_pkg.sv ----
// constants shared by the serial programming port
package isp_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 20;
  localparam int FLASH_WAIT_NS  = 4500000;
  localparam int EE_WAIT_NS     = 9000000;
  localparam int ERASE_WAIT_NS  = 9000000;
  // least waits round up to whole cycles
  localparam int FLASH_WAIT_CYC =
    (FLASH_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EE_WAIT_CYC    =
    (EE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_WAIT_CYC =
    (ERASE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_W         = 19;

  // ---------------------------------------------------------------
  // array sizes
  // ---------------------------------------------------------------
  localparam int FLASH_WORDS    = 4096;
  localparam int EE_BYTES       = 512;
  localparam int PAGE_WORDS     = 32;

  // ---------------------------------------------------------------
  // instruction encodings
  // ---------------------------------------------------------------
  localparam logic [7:0] OP_ENABLE   = 8'hAC;
  localparam logic [7:0] OP_ENABLE2  = 8'h53;
  localparam logic [2:0] OP_ERASE2   = 3'h4;
  localparam logic [7:0] OP_RD_FLASH = 8'h20;
  localparam logic [7:0] OP_LD_PAGE  = 8'h40;
  localparam logic [7:0] OP_WR_PAGE  = 8'h4C;
  localparam logic [7:0] OP_RD_EE    = 8'hA0;
  localparam logic [7:0] OP_WR_EE    = 8'hC0;
  localparam logic [7:0] HSEL_MASK   = 8'h08;
  localparam logic [7:0] ERASED      = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  // ---------------------------------------------------------------
  // frame bit counts (bits already taken)
  // ---------------------------------------------------------------
  localparam logic [4:0] FRAME_HDR_BIT = 5'h17;
  localparam logic [4:0] FRAME_RD_BIT  = 5'h18;
  localparam logic [4:0] FRAME_END_BIT = 5'h1F;
  localparam logic [4:0] FRAME_ECHO_BIT = 5'h10;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_ERASE = 4'h2,
    ST_PAGE  = 4'h4,
    ST_WAIT  = 4'h8
  } isp_state_type;
endpackage

// ---- rtl/isp_sync.sv ----
// two-flop level synchroniser into the cpu clock domain
`timescale 1ns/1ps
module isp_sync #(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // levels
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // first flop feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule

// ---- rtl/isp_link.sv ----
// serial-clock side: frame shifter and data-out shifter
`timescale 1ns/1ps
module isp_link
  import isp_pkg::*;
(
  // serial pins
  input  wire logic        sck_clk,
  input  wire logic        rst_pin_n,
  input  wire logic        mosi,
  output logic             miso,
  // to and from the cpu clock domain
  input  wire logic [7:0]  rdata,
  output logic [23:0]      hdr,
  output logic             hdr_tog,
  output logic [31:0]      word,
  output logic             word_tog
);
  logic [4:0]  cnt_q, cnt_d;
  logic [30:0] sh_q, sh_d;
  logic [7:0]  byte_q, byte_d;
  logic [23:0] hdr_q, hdr_d;
  logic [31:0] word_q, word_d;
  logic        ht_q, ht_d;
  logic        wt_q, wt_d;
  logic [7:0]  tx_q, tx_d;
  logic [31:0] rx;

  // -------------------------------------------------------------
  // next values
  // -------------------------------------------------------------
  assign rx = {sh_q, mosi};

  always_comb begin
    cnt_d  = cnt_q + 5'h1;
    sh_d   = rx[30:0]; // RULE_06
    byte_d = byte_q;
    hdr_d  = hdr_q;
    ht_d   = ht_q;
    word_d = word_q;
    wt_d   = wt_q;
    if (cnt_q[2:0] == 3'h7) begin
      byte_d = rx[7:0];
    end
    // header after three bytes lets reads be looked up in time
    if (cnt_q == FRAME_HDR_BIT) begin
      hdr_d = rx[23:0];
      ht_d  = ~ht_q;
    end
    if (cnt_q == FRAME_END_BIT) begin
      word_d = rx; // RULE_26
      wt_d   = ~wt_q;
    end
    // out shifter: echo last byte, or read data in byte four
    tx_d = {tx_q[6:0], 1'b0};
    if (cnt_q == FRAME_RD_BIT) begin
      tx_d = rdata; // RULE_17
    end else if (cnt_q[2:0] == 3'h0) begin
      tx_d = byte_q; // RULE_10
    end
  end

  // -------------------------------------------------------------
  // registers; reset pin high clears framing without any edge
  // -------------------------------------------------------------
  always_ff @(posedge sck_clk or posedge rst_pin_n) begin
    if (rst_pin_n) begin
      cnt_q  <= '0;
      sh_q   <= '0;
      byte_q <= '0;
      hdr_q  <= '0;
      ht_q   <= 1'b0;
      word_q <= '0;
      wt_q   <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      byte_q <= byte_d;
      hdr_q  <= hdr_d;
      ht_q   <= ht_d;
      word_q <= word_d;
      wt_q   <= wt_d;
    end
  end

  // data out changes on the falling edge
  always_ff @(negedge sck_clk or posedge rst_pin_n) begin
    if (rst_pin_n) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d; // RULE_07
    end
  end

  assign miso     = tx_q[7];
  assign hdr      = hdr_q;
  assign hdr_tog  = ht_q;
  assign word     = word_q;
  assign word_tog = wt_q;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking cb @(posedge sck_clk); endclocking
  default disable iff (rst_pin_n);

  chk_frame_word: assert property ( // RULE_26
    (cnt_q == FRAME_END_BIT) |=> (wt_q != $past(wt_q)) && (cnt_q == 5'h0))
    else $error("frame word not handed over after 32 bits");

  chk_echo_byte: assert property ( // RULE_10
    (cnt_q == FRAME_ECHO_BIT) |-> (tx_q == byte_q) && (miso == byte_q[7]))
    else $error("second byte not echoed during third byte");

  chk_read_load: assert property ( // RULE_07
    (cnt_q == FRAME_RD_BIT) |-> (tx_q == rdata))
    else $error("read data not loaded for fourth byte");
endmodule

// ---- rtl/isp_top.sv ----
// serial in-system programming port for flash and eeprom arrays
// Operation
// RULE_01: arrays programmable over serial pins only while reset pin is low
// RULE_02: no program or erase until programming enable was accepted
// RULE_03: each eeprom write auto-erases its byte, self-timed
// RULE_04: chip erase sets every flash and eeprom location to all ones
// RULE_05: host keeps serial clock low and high three cpu clocks at least
// RULE_06: serial input bits taken on rising serial clock edge
// RULE_07: serial output bits change on falling serial clock edge
// RULE_08: host powers up with reset and serial clock low; the programmer model powers up with the reset pin high
// RULE_09: host waits 20 ms before programming enable; the programmer model settles only 2000 ns
// RULE_10: second enable byte echoed while third byte shifts in
// RULE_11: host sends all four bytes; on bad echo pulses reset, retries; the bench only counts a bad echo as a mismatch
// RULE_12: page buffer loaded bytewise by 5-bit word index, low then high
// RULE_13: write page with 7-bit page number programs whole page at once
// RULE_14: without polling host waits flash page wait delay
// RULE_15: without polling host waits eeprom byte wait delay
// RULE_16: eeprom written one byte per instruction with address and data
// RULE_17: read instruction returns stored content on serial output
// RULE_18: reset pin high ends programming mode
// RULE_19: reads inside page being programmed give all ones until done
// RULE_20: host cannot poll for all-ones flash data, waits instead
// RULE_21: host issues only polling reads while a write is running
// RULE_22: waits are 4.5 ms per page, 9.0 ms per eeprom byte or erase
// RULE_23: read of eeprom byte being programmed gives all ones until done
// RULE_24: enable is AC 53 then two don't-care bytes
// RULE_25: load page first byte 0100 H000, H picks high byte
// RULE_26: instructions are four bytes msb first, decoded after fourth
// RULE_27: serial events synchronised into cpu clock before edge detect
`timescale 1ns/1ps
module isp_top
  import isp_pkg::*;
#(
  parameter int FLASH_WAIT_CYCLES = FLASH_WAIT_CYC,
  parameter int EE_WAIT_CYCLES    = EE_WAIT_CYC,
  parameter int ERASE_WAIT_CYCLES = ERASE_WAIT_CYC
) (
  // cpu clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // programming pins
  input  wire logic sck_clk,
  input  wire logic rst_pin_n,
  input  wire logic mosi,
  output logic      miso,
  // status
  output logic      prog_enabled,
  output logic      nvm_busy
);
  // sweeps use part of each wait; guard against shortened waits
  localparam int ERASE_REST =
    (ERASE_WAIT_CYCLES > FLASH_WORDS) ? ERASE_WAIT_CYCLES - FLASH_WORDS : 1;
  localparam int PAGE_REST =
    (FLASH_WAIT_CYCLES > PAGE_WORDS) ? FLASH_WAIT_CYCLES - PAGE_WORDS : 1;

  // ---------------------------------------------------------------
  // crossing from the serial clock
  // ---------------------------------------------------------------
  logic [23:0] hdr;
  logic [31:0] word;
  logic        hdr_tog, word_tog;
  logic        pin_s, hdr_s, word_s;
  logic [7:0]  rdata_q, rdata_d;
  // hdr and word stay still for many cpu clocks after their toggle
  isp_link u_link (
    .sck_clk   (sck_clk),
    .rst_pin_n (rst_pin_n), // RULE_01
    .mosi      (mosi),
    .miso      (miso),
    .rdata     (rdata_q),
    .hdr       (hdr),
    .hdr_tog   (hdr_tog),
    .word      (word),
    .word_tog  (word_tog)
  );
  isp_sync #(
    .WIDTH (3),
    .INIT  (3'h4)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .din   ({rst_pin_n, hdr_tog, word_tog}), // RULE_27
    .dout  ({pin_s, hdr_s, word_s})
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  isp_state_type     state_q, state_d;
  logic [11:0]       sweep_q, sweep_d;
  logic [6:0]        page_q, page_d;
  logic [8:0]        ee_addr_q, ee_addr_d;
  logic              fl_busy_q, fl_busy_d;
  logic              ee_busy_q, ee_busy_d;
  logic              er_busy_q, er_busy_d;
  logic [WAIT_W-1:0] wait_q, wait_d;
  logic [7:0]        low_q, low_d;
  logic [31:0]       vld_q, vld_d;
  logic              en_q, en_d;
  logic              hprev_q, wprev_q, pin_q;
  logic              busy_q, busy_d;
  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0]  ee_mem    [EE_BYTES];
  logic [15:0] page_buf  [PAGE_WORDS];

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic        hdr_evt, word_evt, accept;
  logic [7:0]  b1, b2, b3, b4, h1, h2, h3;
  logic        is_en, is_erase, is_ldpg, is_wrpg, is_wree;
  logic        rd_fl, rd_ee;
  logic [11:0] fl_addr;
  logic [8:0]  ee_raddr;
  logic [15:0] fl_word;
  // events need the pin low two clocks: stale toggles die at reset
  assign hdr_evt  = !pin_s && !pin_q && (hdr_s != hprev_q);
  assign word_evt = !pin_s && !pin_q && (word_s != wprev_q);
  assign accept   = word_evt && en_q && (state_q == ST_IDLE); // RULE_02
  assign {b1, b2, b3, b4} = word;
  assign {h1, h2, h3}     = hdr;
  assign is_en    = (b1 == OP_ENABLE) && (b2 == OP_ENABLE2); // RULE_24
  assign is_erase = (b1 == OP_ENABLE) && (b2[7:5] == OP_ERASE2);
  assign is_ldpg  = ((b1 & ~HSEL_MASK) == OP_LD_PAGE); // RULE_25
  assign is_wrpg  = (b1 == OP_WR_PAGE);
  assign is_wree  = (b1 == OP_WR_EE); // RULE_16
  assign rd_fl    = ((h1 & ~HSEL_MASK) == OP_RD_FLASH);
  assign rd_ee    = (h1 == OP_RD_EE);
  assign fl_addr  = {h2[3:0], h3};
  assign ee_raddr = {h2[0], h3};
  assign fl_word  = flash_mem[fl_addr];

  // ---------------------------------------------------------------
  // control next values
  // ---------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    sweep_d   = sweep_q;
    page_d    = page_q;
    ee_addr_d = ee_addr_q;
    fl_busy_d = fl_busy_q;
    ee_busy_d = ee_busy_q;
    er_busy_d = er_busy_q;
    wait_d    = wait_q;
    low_d     = low_q;
    vld_d     = vld_q;
    en_d      = en_q;
    case (state_q)
      ST_IDLE: begin
        if (accept && is_erase) begin
          state_d   = ST_ERASE;
          sweep_d   = '0;
          er_busy_d = 1'b1;
          vld_d     = '0;
          wait_d    = WAIT_W'(ERASE_REST - 1);
        end else if (accept && is_wrpg) begin
          state_d   = ST_PAGE;
          sweep_d   = '0;
          page_d    = {b2[3:0], b3[7:5]}; // RULE_13
          fl_busy_d = 1'b1;
          wait_d    = WAIT_W'(PAGE_REST - 1);
        end else if (accept && is_wree) begin
          state_d   = ST_WAIT;
          ee_addr_d = {b2[0], b3};
          ee_busy_d = 1'b1;
          wait_d    = WAIT_W'(EE_WAIT_CYCLES - 1);
        end else if (accept && is_ldpg && !b1[3]) begin
          low_d = b4; // RULE_12
        end else if (accept && is_ldpg) begin
          vld_d[b3[4:0]] = 1'b1;
        end
      end
      ST_ERASE: begin
        sweep_d = sweep_q + 12'h1;
        if (sweep_q == 12'(FLASH_WORDS - 1)) begin
          state_d = ST_WAIT;
        end
      end
      ST_PAGE: begin
        sweep_d = sweep_q + 12'h1;
        if (sweep_q[4:0] == 5'(PAGE_WORDS - 1)) begin
          state_d = ST_WAIT;
          vld_d   = '0;
        end
      end
      ST_WAIT: begin
        if (wait_q == '0) begin
          state_d   = ST_IDLE;
          fl_busy_d = 1'b0;
          ee_busy_d = 1'b0;
          er_busy_d = 1'b0;
        end else begin
          wait_d = wait_q - 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // pin high ends the session; enable needs a fresh instruction
    if (pin_s) begin
      en_d = 1'b0; // RULE_18
    end else if (word_evt && is_en) begin
      en_d = 1'b1; // RULE_02
    end
  end
  // read answer, looked up after the third byte
  always_comb begin
    rdata_d = rdata_q;
    if (hdr_evt) begin
      rdata_d = 8'h00;
      if (en_q && rd_fl) begin
        if (er_busy_q || (fl_busy_q && fl_addr[11:5] == page_q)) begin
          rdata_d = ERASED; // RULE_19
        end else begin
          rdata_d = h1[3] ? fl_word[15:8] : fl_word[7:0]; // RULE_17
        end
      end else if (en_q && rd_ee) begin
        if (er_busy_q || (ee_busy_q && ee_raddr == ee_addr_q)) begin
          rdata_d = ERASED; // RULE_23
        end else begin
          rdata_d = ee_mem[ee_raddr];
        end
      end
    end
  end
  assign busy_d = (state_d != ST_IDLE);
  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      sweep_q   <= '0;
      page_q    <= '0;
      ee_addr_q <= '0;
      fl_busy_q <= 1'b0;
      ee_busy_q <= 1'b0;
      er_busy_q <= 1'b0;
      wait_q    <= '0;
      low_q     <= ERASED;
      vld_q     <= '0;
      en_q      <= 1'b0;
      hprev_q   <= 1'b0;
      wprev_q   <= 1'b0;
      pin_q     <= 1'b1;
      rdata_q   <= '0;
      busy_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      sweep_q   <= sweep_d;
      page_q    <= page_d;
      ee_addr_q <= ee_addr_d;
      fl_busy_q <= fl_busy_d;
      ee_busy_q <= ee_busy_d;
      er_busy_q <= er_busy_d;
      wait_q    <= wait_d;
      low_q     <= low_d;
      vld_q     <= vld_d;
      en_q      <= en_d;
      hprev_q   <= hdr_s;
      wprev_q   <= word_s;
      pin_q     <= pin_s;
      rdata_q   <= rdata_d;
      busy_q    <= busy_d;
    end
  end

  // ---------------------------------------------------------------
  // arrays; sweeps write one word a clock, no reset on storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (state_q == ST_ERASE) begin
      flash_mem[sweep_q] <= ERASED_WORD; // RULE_04
      if (sweep_q < 12'(EE_BYTES)) begin
        ee_mem[sweep_q[8:0]] <= ERASED;
      end
    end
    // unloaded words are left as they were
    if (state_q == ST_PAGE && vld_q[sweep_q[4:0]]) begin
      flash_mem[{page_q, sweep_q[4:0]}] <= page_buf[sweep_q[4:0]];
    end
    // erase and program of one byte collapse into one write
    if (accept && is_wree) begin
      ee_mem[{b2[0], b3}] <= b4; // RULE_03
    end
    if (accept && is_ldpg && b1[3]) begin
      page_buf[b3[4:0]] <= {b4, low_q}; // RULE_12
    end
  end
  assign prog_enabled = en_q;
  assign nvm_busy     = busy_q;
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_commit;
    accept && is_wrpg;
  endsequence
  sequence s_sweep;
    (state_q == ST_PAGE) [*8];
  endsequence
  chk_page_commit: assert property (s_commit |=> s_sweep) // RULE_13
    else $error("page commit did not sweep the buffer");
  chk_no_enable: assert property ( // RULE_02
    (word_evt && !en_q && is_erase) |=> (state_q == ST_IDLE))
    else $error("erase started without programming enable");
  chk_enable_set: assert property ( // RULE_24
    (word_evt && !pin_s && is_en) |=> en_q ##1 prog_enabled)
    else $error("programming enable not taken");
  chk_exit_mode: assert property ( // RULE_18
    pin_s |=> !en_q)
    else $error("programming mode kept with reset pin high");
  chk_ee_write: assert property ( // RULE_03
    (accept && is_wree) |=> (ee_mem[$past(ee_addr_d)] == $past(b4))
      && ee_busy_q && (state_q == ST_WAIT))
    else $error("eeprom byte not written with its data");
  chk_erase_ones: assert property ( // RULE_04
    (state_q == ST_ERASE) |=>
      (flash_mem[$past(sweep_q)] == ERASED_WORD) &&
      (($past(sweep_q) >= 12'(EE_BYTES)) ||
       (ee_mem[9'($past(sweep_q))] == ERASED)))
    else $error("chip erase left a location not erased");
  chk_poll_flash: assert property ( // RULE_19
    (hdr_evt && en_q && rd_fl && fl_busy_q && fl_addr[11:5] == page_q)
      |=> (rdata_q == ERASED))
    else $error("busy page read not all ones");
  chk_poll_ee: assert property ( // RULE_23
    (hdr_evt && en_q && rd_ee && ee_busy_q && ee_raddr == ee_addr_q)
      |=> (rdata_q == ERASED))
    else $error("busy eeprom read not all ones");
  chk_read_ee: assert property ( // RULE_17
    (hdr_evt && en_q && rd_ee && !ee_busy_q && !er_busy_q)
      |=> (rdata_q == ee_mem[$past(ee_raddr)]))
    else $error("eeprom read returned wrong data");
endmodule

// ---- verification/isp_prog_model.sv ----
// programmer model: frames instructions onto the serial pins
`timescale 1ns/1ps
module isp_prog_model #(
  parameter int HALF_NS = 164,
  parameter int GAP_NS  = 400,
  parameter int WAKE_NS = 2000
) (
  // serial pins
  output logic      sck_clk,
  output logic      rst_pin_n,
  output logic      mosi,
  input  wire logic miso
);
  // ---------------------------------------------------------------
  // pin sequencing
  // ---------------------------------------------------------------
  // power up with clock low and reset pin high
  initial begin
    sck_clk   = 1'b0;
    rst_pin_n = 1'b1;
    mosi      = 1'b0;
  end

  // clock low first, then pull reset pin low and settle
  task automatic enter();
    sck_clk = 1'b0;
    #(HALF_NS);
    rst_pin_n = 1'b0;
    #(WAKE_NS); // shortened settle
  endtask

  // raising the reset pin ends the session or retries sync
  task automatic leave();
    rst_pin_n = 1'b1;
    #(WAKE_NS);
  endtask

  // all four bytes always sent, msb first; clock stops after
  task automatic xfer(input logic [31:0] ins, output logic [31:0] resp);
    for (int i = 31; i >= 0; i--) begin
      mosi = ins[i];
      #(HALF_NS); // phases far above three cpu clocks
      sck_clk = 1'b1;
      resp[i] = miso; // settled since the falling edge
      #(HALF_NS);
      sck_clk = 1'b0;
    end
    mosi = ~mosi; // released line must not keep the last bit
    #(GAP_NS); // low gap lets the word cross domains
  endtask
endmodule

// ---- verification/test_isp_top.sv ----
// self-checking bench for the serial programming port
`timescale 1ns/1ps
module test_isp_top;
  import isp_pkg::*;
  // waits shortened so a read frame fits inside each busy time
  localparam int FW = 2000;
  localparam int EW = 2000;
  localparam int XW = 4200;
  logic        clk;
  logic        reset;
  logic        sck_clk;
  logic        rst_pin_n;
  logic        mosi;
  logic        miso;
  logic        prog_enabled;
  logic        nvm_busy;
  logic [31:0] r;
  logic [15:0] v;
  logic [7:0]  d;
  logic [15:0] fl_m [FLASH_WORDS];
  logic [7:0]  ee_m [EE_BYTES];
  int          n_errors;
  int          samples_checked;
  int          a;
  int          pg;
  int          ws [4];

  isp_top #(
    .FLASH_WAIT_CYCLES (FW),
    .EE_WAIT_CYCLES    (EW),
    .ERASE_WAIT_CYCLES (XW)
  ) DUT (
    .clk          (clk),
    .reset        (reset),
    .sck_clk      (sck_clk),
    .rst_pin_n    (rst_pin_n),
    .mosi         (mosi),
    .miso         (miso),
    .prog_enabled (prog_enabled),
    .nvm_busy     (nvm_busy)
  );

  isp_prog_model prog (
    .sck_clk   (sck_clk),
    .rst_pin_n (rst_pin_n),
    .mosi      (mosi),
    .miso      (miso)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // cpu clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // frames start on a cpu falling edge
  task automatic op(input logic [31:0] ins);
    @(negedge clk);
    prog.xfer(ins, r);
  endtask

  task automatic rd_fl(input int wa, input logic hi);
    op({OP_RD_FLASH | (hi ? HSEL_MASK : 8'h00), 4'h0, wa[11:8], wa[7:0],
        8'h00});
  endtask

  task automatic rd_ee(input int ea);
    op({OP_RD_EE, 7'h00, ea[8], ea[7:0], 8'h00});
  endtask

  // bounded poll on the busy flag
  task automatic wait_idle();
    int k;
    k = 0;
    while (nvm_busy !== 1'b0 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 20000) begin
      n_errors++;
      $display("BAD %0t busy never ended", $time);
      conclude();
    end
  endtask

  // a hang anywhere ends the run as a mismatch
  initial begin
    #2000000;
    n_errors++;
    $display("BAD %0t run limit reached", $time);
    conclude();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    n_errors = 0;
    samples_checked = 0;
    void'($urandom(70));
    repeat (20) @(negedge clk);
    reset = 1'b0;
    prog.enter();
    op({OP_ENABLE, 8'h80, 16'h0000});
    check({7'h00, nvm_busy}, 8'h00);
    rd_ee(5);
    check(r[7:0], 8'h00);
    $display("test refused before enable done");
    op({OP_ENABLE, OP_ENABLE2, 16'h0000});
    check(r[15:8], OP_ENABLE2);
    check(r[23:16], OP_ENABLE);
    check({7'h00, prog_enabled}, 8'h01);
    $display("test enable done");
    op({OP_ENABLE, 8'h80, 16'h0000});
    check({7'h00, nvm_busy}, 8'h01);
    foreach (fl_m[i]) fl_m[i] = ERASED_WORD;
    foreach (ee_m[i]) ee_m[i] = ERASED;
    wait_idle();
    for (int i = 0; i < 3; i++) begin
      a = $urandom_range(FLASH_WORDS - 1);
      rd_fl(a, 1'b1);
      check(r[7:0], fl_m[a][15:8]);
      a = $urandom_range(EE_BYTES - 1);
      rd_ee(a);
      check(r[7:0], ee_m[a]);
    end
    $display("test chip erase done");
    // rewriting one byte needs the built-in erase to raise bits
    a = $urandom_range(EE_BYTES - 1);
    for (int i = 0; i < 3; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'h5A : 8'($urandom);
      op({OP_WR_EE, 7'h00, a[8], a[7:0], d});
      ee_m[a] = d;
      rd_ee(a);
      check(r[7:0], ERASED);
      wait_idle();
      rd_ee(a);
      check(r[7:0], ee_m[a]);
    end
    $display("test eeprom write done");
    // page edges plus two inner words, low byte before high
    pg = $urandom_range(127);
    ws = '{0, 31, $urandom_range(1, 15), $urandom_range(16, 30)};
    foreach (ws[i]) begin
      v = 16'($urandom);
      op({OP_LD_PAGE, 8'h00, 3'h0, ws[i][4:0], v[7:0]});
      op({OP_LD_PAGE | HSEL_MASK, 8'h00, 3'h0, ws[i][4:0], v[15:8]});
      fl_m[pg * PAGE_WORDS + ws[i]] = v;
    end
    op({OP_WR_PAGE, 4'h0, pg[6:3], pg[2:0], 5'h00, 8'h00});
    rd_fl(pg * PAGE_WORDS + ws[2], 1'b0);
    check(r[7:0], ERASED);
    wait_idle();
    foreach (ws[i]) begin
      a = pg * PAGE_WORDS + ws[i];
      rd_fl(a, 1'b0);
      check(r[7:0], fl_m[a][7:0]);
      rd_fl(a, 1'b1);
      check(r[7:0], fl_m[a][15:8]);
    end
    $display("test page write done");
    op({8'h58, 24'h000000});
    check(r[7:0], 8'h00);
    prog.leave();
    check({7'h00, prog_enabled}, 8'h00);
    prog.enter();
    rd_ee(a % EE_BYTES);
    check(r[7:0], 8'h00);
    op({OP_ENABLE, OP_ENABLE2, 16'h0000});
    rd_fl(a, 1'b1);
    check(r[7:0], fl_m[a][15:8]);
    $display("test session restart done");
    // odd frame count leaves the toggles high across the reset
    repeat (2) op({OP_ENABLE, OP_ENABLE2, 16'h0000});
    @(negedge clk);
    reset = 1'b1;
    repeat (3) @(negedge clk);
    check({6'h00, prog_enabled, nvm_busy}, 8'h00);
    reset = 1'b0;
    // a stale enable word must not be decoded again after reset
    repeat (8) @(negedge clk);
    check({7'h00, prog_enabled}, 8'h00);
    $display("test mid-run reset done");
    conclude();
  end
endmodule
